// ==== sbgtx_consts.svh ====
`ifndef SBGTX_CONSTS_SVH
`define SBGTX_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------------
`define SBGTX_IDX_FRAC_CTRL 10'h004
`define SBGTX_IDX_FRAC_ACCUM 10'h006
`define SBGTX_IDX_BAUD_CTRL 10'h01c
`define SBGTX_IDX_BAUD_OUTCFG 10'h01e
`define SBGTX_IDX_TX_CTRL 10'h020
`define SBGTX_IDX_SHIFT_CTRL 10'h021
`define SBGTX_IDX_PROTO_CTRL 10'h022
`define SBGTX_IDX_STATUS 10'h023
`define SBGTX_IDX_TXBUF_BASE 10'h040
`define SBGTX_TXBUF_LOCS 10'h020

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define SBGTX_STEP_MSB 9
`define SBGTX_DM_LSB 14
`define SBGTX_CLOCK_SOURCE_SEL_LSB 0
`define SBGTX_MEASUREMENT_ENABLE_BIT 3
`define SBGTX_PRESCALE_HALF_ENABLE_BIT 4
`define SBGTX_QUANTA_INPUT_SEL_LSB 6
`define SBGTX_QUANTA_PREDIVIDER_LSB 8
`define SBGTX_QUANTA_DENOMINATOR_LSB 10
`define SBGTX_MASTER_CLOCK_OUT_LEVEL_BIT 13
`define SBGTX_SHIFT_CLOCK_OUT_CFG_LSB 14
`define SBGTX_WORD_LEN_CTRL_MODE_BIT 0
`define SBGTX_FRAME_LEN_CTRL_MODE_BIT 1
`define SBGTX_SELECT_OUT_CTRL_MODE_BIT 2
`define SBGTX_WORD_ADDR_CTRL_MODE_BIT 3
`define SBGTX_EOF_BIT 4
`define SBGTX_WA_BIT 5
`define SBGTX_FLE_LSB 8
`define SBGTX_CTR_LSB 16

// ----------------------------------------------------------------------------
// Reset and start values.
// ----------------------------------------------------------------------------
`define SBGTX_RST_16 16'h0000
`define SBGTX_ACCUM_START 10'h3ff
`define SBGTX_CNT_MAX 10'h3ff
`define SBGTX_RST_WLE 4'hf
`define SBGTX_RST_FLE 6'h0f
`define SBGTX_RESP_OKAY 2'b00
`define SBGTX_RESP_SLVERR 2'b10

`endif

// ==== sbgtx_pkg.sv ====
package sbgtx_pkg;
	typedef enum logic [1:0] {
		SBGTX_DM_OFF0 = 2'b00,
		SBGTX_DM_NORMAL = 2'b01,
		SBGTX_DM_FRAC = 2'b10,
		SBGTX_DM_OFF3 = 2'b11
	} sbgtx_dm_e;
	typedef enum logic [1:0] {
		SBGTX_TX_IDLE = 2'b01,
		SBGTX_TX_SHIFT = 2'b10
	} sbgtx_tx_e;
	typedef logic [9:0] sbgtx_cnt_t;
endpackage

// ==== sbgtx_serial_baud_gen.sv ====
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "sbgtx_consts.svh"
module sbgtx_serial_baud_gen (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic input0_pin,
	input wire logic input1_pin,
	output logic master_clock_pin_out,
	output logic shift_clock_pin_out,
	output logic data_out,
	output logic tx_shift_event,
	output logic time_quantum,
	output logic quanta_window_done,
	output logic transfers_allowed
);
	import sbgtx_pkg::*;

	// ------------------------------------------------------------------------
	// Helpers.
	// ------------------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic is_txbuf(input logic [9:0] idx);
		return (idx >= `SBGTX_IDX_TXBUF_BASE) &&
			(idx < (`SBGTX_IDX_TXBUF_BASE + `SBGTX_TXBUF_LOCS));
	endfunction

	// ------------------------------------------------------------------------
	// Register storage.
	// ------------------------------------------------------------------------
	logic [9:0] step_ff;
	logic [1:0] dm_ff;
	logic [9:0] accum_ff;
	logic [1:0] accum_rsv_ff;
	logic [15:0] baud_ctrl_ff;
	logic [9:0] divider_factor_ff;
	logic master_clock_out_level_ff;
	logic [1:0] shift_clock_out_cfg_ff;
	logic [5:0] tx_ctrl_ff;
	logic [3:0] word_length_field_ff;
	logic [5:0] frame_length_field_ff;
	logic [7:0] protocol_ctrl_bits_ff;
	logic [15:0] tx_buffer_ff;
	logic tx_buffer_valid_ff;

	// ------------------------------------------------------------------------
	// Bus slave.
	// ------------------------------------------------------------------------
	logic aw_held_ff;
	logic w_held_ff;
	logic [9:0] aw_idx_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic wr_fire;
	logic [31:0] rd_word;
	logic rd_hit;

	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = !w_held_ff && !bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			aw_idx_ff <= 10'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_ff <= 1'b1;
			aw_idx_ff <= s_axi_awaddr[11:2];
		end else if (wr_fire) begin
			aw_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_ff <= 1'b0;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_ff <= 1'b1;
			wdata_ff <= s_axi_wdata;
			wstrb_ff <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= `SBGTX_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (aw_idx_ff <= `SBGTX_IDX_PROTO_CTRL && aw_idx_ff >= `SBGTX_IDX_FRAC_CTRL &&
				(aw_idx_ff == `SBGTX_IDX_FRAC_CTRL || aw_idx_ff == `SBGTX_IDX_FRAC_ACCUM ||
				aw_idx_ff == `SBGTX_IDX_BAUD_CTRL || aw_idx_ff == `SBGTX_IDX_BAUD_OUTCFG ||
				aw_idx_ff >= `SBGTX_IDX_TX_CTRL)) || is_txbuf(aw_idx_ff) ?
				`SBGTX_RESP_OKAY : `SBGTX_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	logic [9:0] meas_cnt_ff;
	sbgtx_tx_e tx_state_ff;

	always_comb begin
		rd_hit = 1'b1;
		rd_word = 32'h0000_0000;
		case (s_axi_araddr[11:2])
			`SBGTX_IDX_FRAC_CTRL: rd_word[15:0] = {dm_ff, 4'h0, step_ff};
			`SBGTX_IDX_FRAC_ACCUM: rd_word[15:0] = {accum_rsv_ff, 4'h0, accum_ff};
			`SBGTX_IDX_BAUD_CTRL: rd_word[15:0] = baud_ctrl_ff;
			`SBGTX_IDX_BAUD_OUTCFG: rd_word[15:0] = {shift_clock_out_cfg_ff,
				master_clock_out_level_ff, 3'h0, divider_factor_ff};
			`SBGTX_IDX_TX_CTRL: rd_word[5:0] = tx_ctrl_ff;
			`SBGTX_IDX_SHIFT_CTRL: rd_word[13:0] = {frame_length_field_ff, 4'h0,
				word_length_field_ff};
			`SBGTX_IDX_PROTO_CTRL: rd_word[23:16] = protocol_ctrl_bits_ff;
			`SBGTX_IDX_STATUS: rd_word = {6'h00, meas_cnt_ff, 14'h0000,
				tx_state_ff == SBGTX_TX_SHIFT, tx_buffer_valid_ff};
			default: rd_hit = is_txbuf(s_axi_araddr[11:2]);
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= `SBGTX_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_word;
			rresp_ff <= rd_hit ? `SBGTX_RESP_OKAY : `SBGTX_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	logic [31:0] wmerged;
	logic [4:0] tx_control_info;
	logic txbuf_wr;
	assign wmerged = merge(32'h0000_0000, wdata_ff, wstrb_ff);
	assign txbuf_wr = wr_fire && is_txbuf(aw_idx_ff);
	assign tx_control_info = aw_idx_ff[4:0];

	// ------------------------------------------------------------------------
	// Fractional divider.
	// ------------------------------------------------------------------------
	logic frac_div_pulse;
	logic [10:0] accum_sum;
	logic dm_start;
	assign accum_sum = {1'b0, accum_ff} + {1'b0, step_ff};
	assign dm_start = wr_fire && aw_idx_ff == `SBGTX_IDX_FRAC_CTRL && wstrb_ff[1] &&
		(wdata_ff[15:14] == SBGTX_DM_NORMAL || wdata_ff[15:14] == SBGTX_DM_FRAC);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_ff <= 10'h000;
			dm_ff <= SBGTX_DM_OFF0;
		end else if (wr_fire && aw_idx_ff == `SBGTX_IDX_FRAC_CTRL) begin
			step_ff <= {wstrb_ff[1] ? wdata_ff[9:8] : step_ff[9:8],
				wstrb_ff[0] ? wdata_ff[7:0] : step_ff[7:0]};
			if (wstrb_ff[1]) begin
				dm_ff <= wdata_ff[`SBGTX_DM_LSB +: 2];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			accum_rsv_ff <= 2'b00;
		end else if (wr_fire && aw_idx_ff == `SBGTX_IDX_FRAC_ACCUM && wstrb_ff[1]) begin
			accum_rsv_ff <= wdata_ff[15:14];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			accum_ff <= 10'h000;
			frac_div_pulse <= 1'b0;
		end else if (dm_start) begin
			accum_ff <= `SBGTX_ACCUM_START;
			frac_div_pulse <= 1'b0;
		end else begin
			case (dm_ff)
				SBGTX_DM_NORMAL: begin
					if (accum_ff == `SBGTX_CNT_MAX) begin
						accum_ff <= step_ff;
					end else begin
						accum_ff <= accum_ff + 10'h001;
					end
					frac_div_pulse <= accum_ff == `SBGTX_CNT_MAX;
				end
				SBGTX_DM_FRAC: begin
					accum_ff <= accum_sum[9:0];
					frac_div_pulse <= accum_sum[10];
				end
				default: frac_div_pulse <= 1'b0;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Input synchronisers and triggers.
	// ------------------------------------------------------------------------
	logic [1:0] in0_sync_ff;
	logic [1:0] in1_sync_ff;
	logic in0_prev_ff;
	logic in1_prev_ff;
	logic input0_trigger;
	logic input1_trigger;
	logic input1_synced;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in0_sync_ff <= 2'b00;
			in1_sync_ff <= 2'b00;
			in0_prev_ff <= 1'b0;
			in1_prev_ff <= 1'b0;
		end else begin
			in0_sync_ff <= {in0_sync_ff[0], input0_pin};
			in1_sync_ff <= {in1_sync_ff[0], input1_pin};
			in0_prev_ff <= in0_sync_ff[1];
			in1_prev_ff <= in1_sync_ff[1];
		end
	end
	assign input1_synced = in1_sync_ff[1];
	assign input0_trigger = in0_sync_ff[1] && !in0_prev_ff;
	assign input1_trigger = input1_synced && !in1_prev_ff;

	// ------------------------------------------------------------------------
	// Pin, master clock and pre-processor enables.
	// ------------------------------------------------------------------------
	logic [1:0] clock_source_sel;
	logic measurement_enable;
	logic prescale_half_enable;
	logic [1:0] quanta_input_sel;
	logic [1:0] quanta_predivider;
	logic [4:0] quanta_denominator;
	logic pin_pulse;
	logic mclk_toggle_ff;
	logic master_level;
	logic mclk_pulse;
	logic preproc_pulse;
	assign clock_source_sel = baud_ctrl_ff[`SBGTX_CLOCK_SOURCE_SEL_LSB +: 2];
	assign measurement_enable = baud_ctrl_ff[`SBGTX_MEASUREMENT_ENABLE_BIT];
	assign prescale_half_enable = baud_ctrl_ff[`SBGTX_PRESCALE_HALF_ENABLE_BIT];
	assign quanta_input_sel = baud_ctrl_ff[`SBGTX_QUANTA_INPUT_SEL_LSB +: 2];
	assign quanta_predivider = baud_ctrl_ff[`SBGTX_QUANTA_PREDIVIDER_LSB +: 2];
	assign quanta_denominator = baud_ctrl_ff[`SBGTX_QUANTA_DENOMINATOR_LSB +: 5];

	logic [31:0] baud_merged;
	assign baud_merged = merge({16'h0000, baud_ctrl_ff}, wdata_ff, wstrb_ff);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			baud_ctrl_ff <= `SBGTX_RST_16;
		end else if (wr_fire && aw_idx_ff == `SBGTX_IDX_BAUD_CTRL) begin
			baud_ctrl_ff <= baud_merged[15:0] & 16'h7fdb;
		end
	end

	always_comb begin
		case (clock_source_sel)
			2'b00: pin_pulse = frac_div_pulse;
			2'b10: pin_pulse = input1_trigger;
			2'b11: pin_pulse = input1_trigger;
			default: pin_pulse = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mclk_toggle_ff <= 1'b0;
		end else if (pin_pulse) begin
			mclk_toggle_ff <= !mclk_toggle_ff;
		end
	end
	assign master_level = (clock_source_sel == 2'b11) ? input1_synced : mclk_toggle_ff;
	assign mclk_pulse = pin_pulse && (clock_source_sel == 2'b11 || !mclk_toggle_ff);
	assign preproc_pulse = prescale_half_enable ? mclk_pulse : pin_pulse;

	// ------------------------------------------------------------------------
	// Protocol divider and capture counter.
	// ------------------------------------------------------------------------
	logic div_pulse;
	logic meas_trigger;
	logic sclk_ff;
	logic sclk_dly_ff;
	assign meas_trigger = measurement_enable && (input0_trigger || input1_trigger);
	assign transfers_allowed = !measurement_enable;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meas_cnt_ff <= 10'h000;
			div_pulse <= 1'b0;
			tx_shift_event <= 1'b0;
		end else begin
			div_pulse <= 1'b0;
			tx_shift_event <= meas_trigger;
			if (meas_trigger) begin
				meas_cnt_ff <= 10'h000;
			end else if (preproc_pulse) begin
				if (measurement_enable) begin
					if (meas_cnt_ff != `SBGTX_CNT_MAX) begin
						meas_cnt_ff <= meas_cnt_ff + 10'h001;
					end
				end else if (meas_cnt_ff >= divider_factor_ff) begin
					meas_cnt_ff <= 10'h000;
					div_pulse <= 1'b1;
				end else begin
					meas_cnt_ff <= meas_cnt_ff + 10'h001;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			divider_factor_ff <= 10'h000;
			master_clock_out_level_ff <= 1'b0;
			shift_clock_out_cfg_ff <= 2'b00;
		end else begin
			if (wr_fire && aw_idx_ff == `SBGTX_IDX_BAUD_OUTCFG) begin
				divider_factor_ff <= {wstrb_ff[1] ? wdata_ff[9:8] : divider_factor_ff[9:8],
					wstrb_ff[0] ? wdata_ff[7:0] : divider_factor_ff[7:0]};
				if (wstrb_ff[1]) begin
					master_clock_out_level_ff <= wdata_ff[`SBGTX_MASTER_CLOCK_OUT_LEVEL_BIT];
					shift_clock_out_cfg_ff <= wdata_ff[`SBGTX_SHIFT_CLOCK_OUT_CFG_LSB +: 2];
				end
			end
			if (meas_trigger) begin
				divider_factor_ff <= meas_cnt_ff;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sclk_ff <= 1'b0;
			sclk_dly_ff <= 1'b0;
		end else if (div_pulse) begin
			sclk_ff <= !sclk_ff;
			sclk_dly_ff <= sclk_ff;
		end
	end

	// ------------------------------------------------------------------------
	// Time quanta.
	// ------------------------------------------------------------------------
	logic quanta_in_pulse;
	logic [1:0] qpre_cnt_ff;
	logic [4:0] qden_cnt_ff;
	always_comb begin
		case (quanta_input_sel)
			2'b00: quanta_in_pulse = div_pulse;
			2'b01: quanta_in_pulse = preproc_pulse;
			2'b10: quanta_in_pulse = div_pulse && sclk_ff;
			default: quanta_in_pulse = mclk_pulse;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			qpre_cnt_ff <= 2'b00;
			qden_cnt_ff <= 5'h00;
			time_quantum <= 1'b0;
			quanta_window_done <= 1'b0;
		end else begin
			time_quantum <= 1'b0;
			quanta_window_done <= 1'b0;
			if (quanta_in_pulse) begin
				if (qpre_cnt_ff >= quanta_predivider) begin
					qpre_cnt_ff <= 2'b00;
					time_quantum <= 1'b1;
					if (qden_cnt_ff >= quanta_denominator) begin
						qden_cnt_ff <= 5'h00;
						quanta_window_done <= 1'b1;
					end else begin
						qden_cnt_ff <= qden_cnt_ff + 5'h01;
					end
				end else begin
					qpre_cnt_ff <= qpre_cnt_ff + 2'b01;
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// Clock outputs: level sampled at each phase change, so no short pulses.
	// ------------------------------------------------------------------------
	logic master_prev_ff;
	logic sclk_phase;
	logic sclk_phase_prev_ff;
	assign sclk_phase = shift_clock_out_cfg_ff[1] ? sclk_dly_ff : sclk_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			master_prev_ff <= 1'b0;
			sclk_phase_prev_ff <= 1'b0;
			master_clock_pin_out <= 1'b0;
			shift_clock_pin_out <= 1'b0;
		end else begin
			master_prev_ff <= master_level;
			sclk_phase_prev_ff <= sclk_phase;
			if (master_level != master_prev_ff) begin
				master_clock_pin_out <= master_level ^ master_clock_out_level_ff;
			end
			if (sclk_phase != sclk_phase_prev_ff) begin
				shift_clock_pin_out <= sclk_phase ^ shift_clock_out_cfg_ff[0];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Transmit buffer, control information and shift register.
	// ------------------------------------------------------------------------
	logic [15:0] tx_shift_reg_ff;
	logic [3:0] bits_left_ff;
	logic shift_edge;
	logic tx_load;
	logic [31:0] txbuf_merged;
	assign txbuf_merged = merge({16'h0000, tx_buffer_ff}, wdata_ff, wstrb_ff);
	assign shift_edge = div_pulse && sclk_ff;
	assign tx_load = shift_edge && bits_left_ff == 4'h0 && tx_buffer_valid_ff && transfers_allowed;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_buffer_ff <= 16'h0000;
			tx_buffer_valid_ff <= 1'b0;
		end else if (txbuf_wr) begin
			tx_buffer_ff <= txbuf_merged[15:0];
			tx_buffer_valid_ff <= 1'b1;
		end else if (tx_load) begin
			tx_buffer_valid_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_ctrl_ff <= 6'h00;
			word_length_field_ff <= `SBGTX_RST_WLE;
			frame_length_field_ff <= `SBGTX_RST_FLE;
			protocol_ctrl_bits_ff <= 8'h00;
		end else if (txbuf_wr) begin
			if (tx_ctrl_ff[`SBGTX_WORD_LEN_CTRL_MODE_BIT]) begin
				word_length_field_ff <= tx_control_info[3:0];
				tx_ctrl_ff[`SBGTX_EOF_BIT] <= tx_control_info[4];
			end
			if (tx_ctrl_ff[`SBGTX_FRAME_LEN_CTRL_MODE_BIT]) begin
				frame_length_field_ff <= {1'b0, tx_control_info};
			end
			if (tx_ctrl_ff[`SBGTX_SELECT_OUT_CTRL_MODE_BIT]) begin
				protocol_ctrl_bits_ff <= {3'b000, tx_control_info};
			end
			if (tx_ctrl_ff[`SBGTX_WORD_ADDR_CTRL_MODE_BIT]) begin
				tx_ctrl_ff[`SBGTX_WA_BIT] <= tx_control_info[4];
			end
		end else if (wr_fire) begin
			if (aw_idx_ff == `SBGTX_IDX_TX_CTRL && wstrb_ff[0]) begin
				tx_ctrl_ff <= wmerged[5:0];
			end
			if (aw_idx_ff == `SBGTX_IDX_SHIFT_CTRL && wstrb_ff[0]) begin
				word_length_field_ff <= wmerged[3:0];
			end
			if (aw_idx_ff == `SBGTX_IDX_SHIFT_CTRL && wstrb_ff[1]) begin
				frame_length_field_ff <= wmerged[`SBGTX_FLE_LSB +: 6];
			end
			if (aw_idx_ff == `SBGTX_IDX_PROTO_CTRL && wstrb_ff[2]) begin
				protocol_ctrl_bits_ff <= wmerged[`SBGTX_CTR_LSB +: 8];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_state_ff <= SBGTX_TX_IDLE;
			tx_shift_reg_ff <= 16'h0000;
			bits_left_ff <= 4'h0;
			data_out <= 1'b0;
		end else begin
			case (tx_state_ff)
				SBGTX_TX_IDLE: begin
					if (tx_load) begin
						tx_shift_reg_ff <= {1'b0, tx_buffer_ff[15:1]};
						data_out <= tx_buffer_ff[0];
						bits_left_ff <= word_length_field_ff;
						tx_state_ff <= (word_length_field_ff == 4'h0) ? SBGTX_TX_IDLE :
							SBGTX_TX_SHIFT;
					end
				end
				SBGTX_TX_SHIFT: begin
					if (shift_edge) begin
						data_out <= tx_shift_reg_ff[0];
						tx_shift_reg_ff <= {1'b0, tx_shift_reg_ff[15:1]};
						bits_left_ff <= bits_left_ff - 4'h1;
						if (bits_left_ff == 4'h1) begin
							tx_state_ff <= SBGTX_TX_IDLE;
						end
					end
				end
				default: tx_state_ff <= SBGTX_TX_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== sbgtx_peer.sv ====
`timescale 1ns/100ps
`default_nettype none
module sbgtx_peer (
	ext_run,
	input1_pin
);
	input wire logic ext_run;
	output logic input1_pin;
	// External reference: a rising edge every 6 aclk cycles while enabled, low when idle.
	initial begin
		input1_pin = 1'b0;
		forever begin
			#120;
			input1_pin = ext_run & !input1_pin;
		end
	end
endmodule
`default_nettype wire

// ==== sbgtx_serial_baud_gen_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module sbgtx_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic tx_shift_event,
	input wire logic time_quantum,
	input wire logic transfers_allowed
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wr_answer_a:
		assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##2 s_axi_bvalid) else $error("write response not on time");
	rd_answer_a:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
			else $error("read response not on time");
	b_hold_a:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
			else $error("write response dropped");
	r_hold_a:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
			else $error("read data dropped");
	ar_block_a:
		assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
	aw_block_a:
		assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
			else $error("write taken while busy");
	evt_pulse_a:
		assert property (tx_shift_event |=> !tx_shift_event) else $error("shift event too long");
	evt_meas_a:
		assert property (tx_shift_event |-> !transfers_allowed) else $error("event outside capture");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (tx_shift_event);
	cover property (time_quantum);
endmodule
bind sbgtx_serial_baud_gen sbgtx_checker u_chk (.*);
`default_nettype wire

// ==== sbgtx_serial_baud_gen_tx_buffer_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module sbgtx_serial_baud_gen_tx_buffer_tb_top;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ext_run;
	logic input0_pin, input1_pin, master_clock_pin_out, shift_clock_pin_out, data_out;
	logic tx_shift_event, time_quantum, quanta_window_done, transfers_allowed;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, wrsp, pins;
	logic watch_win;
	int miscompares, num_checks, per, n;
	sbgtx_serial_baud_gen DUT (.*);
	sbgtx_peer peer (.ext_run(ext_run), .input1_pin(input1_pin));
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	// ------------------------------
	// Checks and bus tasks.
	// ------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic test_done;
		if (miscompares == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Ready is raised one cycle after valid is seen, so held responses are exercised.
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic ta, tw, bv, tb;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			bv = s_axi_bvalid;
			wrsp = s_axi_bresp;
			tb = bv & s_axi_bready;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			s_axi_bready <= bv & !tb;
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic ta, rv, tr;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			rv = s_axi_rvalid;
			tr = rv & s_axi_rready;
			rdat = s_axi_rdata;
			rrsp = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			s_axi_rready <= rv & !tr;
		end
		chk(rdat, e);
	endtask
	function automatic logic seen();
		return watch_win ? quanta_window_done : time_quantum;
	endfunction
	// Period of the watched pulse in cycles, 0 when it never pulses.
	// The clock pins are kept as they stand at its first pulse.
	task automatic cfg(input logic [15:0] f, input logic [15:0] b, input logic [15:0] o,
			input int e);
		wr(12'h010, {16'h0, f});
		wr(12'h070, {16'h0, b});
		wr(12'h078, {16'h0, o});
		repeat (40) @(negedge aclk);
		for (n = 0; n < 60 && seen() !== 1'b1; n++) @(negedge aclk);
		pins = {shift_clock_pin_out, master_clock_pin_out};
		per = 0;
		for (n = 0; n < 60 && per < 60; n++) begin
			@(negedge aclk);
			per++;
			if (seen() === 1'b1) break;
		end
		if (per == 60) per = 0;
		@(posedge aclk);
		chk(32'(per), 32'(e));
	endtask
	task automatic cinfo(input logic [11:0] pa, input logic [31:0] pv, input logic [3:0] m,
			input logic [4:0] x, input logic [11:0] ca, input logic [31:0] e);
		wr(pa, pv);
		wr(12'h080, {28'h0, m});
		wr(12'h100 + {5'h0, x, 2'b00}, 32'hd);
		rd(ca, e);
	endtask
	// ------------------------------
	// Test sequence.
	// ------------------------------
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{input0_pin, ext_run, aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		watch_win = 1'b0;
		miscompares = 0;
		num_checks = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(12'h010, 32'h0);
		rd(12'h018, 32'h0);
		rd(12'h070, 32'h0);
		rd(12'h078, 32'h0);
		wr(12'h070, 32'hffff);
		rd(12'h070, 32'h7fdb);
		rd(12'h200, 32'h0);
		chk({30'h0, rrsp}, 32'h2);
		wr(12'h200, 32'h0);
		chk({30'h0, wrsp}, 32'h2);
		wr(12'h018, 32'h0);
		chk({30'h0, wrsp}, 32'h0);
		ext_run <= 1'b1;
		cfg(16'h43fc, 16'h0000, 16'h0000, 4);
		cfg(16'h8100, 16'h0000, 16'h0000, 4);
		cfg(16'h8200, 16'h0000, 16'h0000, 2);
		cfg(16'h43fc, 16'h0100, 16'h0000, 8);
		cfg(16'h43fc, 16'h0000, 16'h0001, 8);
		cfg(16'h43fc, 16'h0010, 16'h0000, 8);
		cfg(16'h43fc, 16'h0040, 16'h0000, 4);
		cfg(16'h43fc, 16'h0080, 16'h0000, 8);
		chk({31'h0, pins[1]}, 32'h1);
		cfg(16'h43fc, 16'h0080, 16'h4000, 8);
		chk({31'h0, pins[1]}, 32'h0);
		cfg(16'h43fc, 16'h0080, 16'h8000, 8);
		chk({31'h0, pins[1]}, 32'h0);
		cfg(16'h43fc, 16'h00c0, 16'h0000, 8);
		chk({31'h0, pins[0]}, 32'h0);
		cfg(16'h43fc, 16'h00c0, 16'h2000, 8);
		chk({31'h0, pins[0]}, 32'h1);
		cfg(16'h43fc, 16'h0003, 16'h0000, 6);
		cfg(16'h43fc, 16'h0002, 16'h0000, 6);
		cfg(16'h43fc, 16'h0001, 16'h0000, 0);
		watch_win = 1'b1;
		cfg(16'h43fc, 16'h0400, 16'h0000, 8);
		watch_win = 1'b0;
		cfg(16'h0000, 16'h0000, 16'h0000, 0);
		cfg(16'hc3fc, 16'h0000, 16'h0000, 0);
		ext_run <= 1'b0;
		wr(12'h010, 32'h43ff);
		wr(12'h070, 32'h0008);
		chk({31'h0, transfers_allowed}, 32'h0);
		repeat (1100) @(posedge aclk);
		input0_pin <= 1'b1;
		for (n = 0; n < 20 && tx_shift_event !== 1'b1; n++) @(negedge aclk);
		chk({31'h0, tx_shift_event}, 32'h1);
		@(posedge aclk);
		input0_pin <= 1'b0;
		rd(12'h078, 32'h03ff);
		wr(12'h070, 32'h0);
		chk({31'h0, transfers_allowed}, 32'h1);
		wr(12'h078, 32'h0);
		wr(12'h010, 32'h43fe);
		cinfo(12'h084, 32'h3f00, 4'h1, 5'h13, 12'h084, 32'h3f03);
		rd(12'h080, 32'h11);
		repeat (300) @(negedge aclk);
		chk({31'h0, data_out}, 32'h1);
		@(posedge aclk);
		rd(12'h08c, 32'h0);
		cinfo(12'h084, 32'h3f03, 4'h2, 5'h1f, 12'h084, 32'h1f03);
		cinfo(12'h088, 32'hff0000, 4'h4, 5'h05, 12'h088, 32'h050000);
		cinfo(12'h084, 32'h0, 4'h8, 5'h10, 12'h080, 32'h28);
		test_done();
	end
	initial begin
		#3000000;
		miscompares++;
		test_done();
	end
endmodule
`default_nettype wire
